// >>> pdr_checker.sv
// Purpose: Assertions on the port register block at its pins.
// Assumes: Zero-wait APB; port 6 is byte 3 of the pin vectors.
// Notes: Pin effects of a write are checked two edges after it.
`timescale 1ns/1ps
module pdr_checker (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [55:0] pin_in,
   input wire logic [55:0] pin_out,
   input wire logic [55:0] pin_oe,
   input wire logic [7:0] timer_f_control
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   // Decode the access edge of reads and strobed writes.
   wire logic acc = psel && penable && pready && paddr[31:18] == 14'h0;
   wire logic [15:0] idx = paddr[17:2];
   wire logic rd = acc && !pwrite;
   wire logic wr = acc && pwrite && pstrb[0];
   dir_reads_ones_a:
      assert property (rd && idx inside {16'hffe4, 16'hffe5, 16'hffe8, 16'hffe9, 16'hffea, 16'hffeb, 16'hffed}
      |-> prdata == 32'hff) else $error("direction read not all ones");
   dir_sets_oe_a:
      assert property (wr && idx == 16'hffe9 |-> ##2 pin_oe[31:24] == $past(pwdata[7:0], 2))
      else $error("direction write not on pin enables");
   data_drives_out_a:
      assert property (wr && idx == 16'hffd9 |-> ##2 pin_out[31:24] == $past(pwdata[7:0], 2))
      else $error("data write not on pin outputs");
   data_read_mix_a:
      assert property (rd && idx == 16'hffd9 && $stable(pin_oe[31:24]) && $stable(pin_out[31:24])
      |-> prdata == {24'h0, pin_oe[31:24] & pin_out[31:24] | ~pin_oe[31:24] & $past(pin_in[31:24])})
      else $error("data read mixes pins wrongly");
   timer_wo_bits_a:
      assert property (rd && idx == 16'hffb6 |-> prdata == {24'h0, 4'hf, timer_f_control[3:0]})
      else $error("timer control read wrong");
   reset_inputs_a:
      assert property (disable iff (1'b0) srst |=> pin_oe == 56'h0 && timer_f_control == 8'h0)
      else $error("reset left pins driven");
endmodule // pdr_checker
bind pdr_top pdr_checker i_chk (.*);

// >>> pdr_pkg.sv
// Purpose: Constants and types shared by the parallel port direction and data register block.
// Assumes: APB with 32-bit data, byte registers in the low lane of one aligned word each.
// Notes: Printed offsets are not all multiples of four, so each is a register index; byte address is index times four.
//
// Summary of operation
// - A read of any port direction register returns all ones.
// - Direction bit zero makes its pin an input, one makes it an output.
// - A write to a direction register replaces all eight bits at once.
// - The data register address also reads the port input pins.
// - Timer F control register holds write-only bits that do not read back.
// - Data read gives pin level for inputs and stored bit for outputs.
package pdr_pkg;
   //-----------------------------------------------------------------
   // Port layout
   //-----------------------------------------------------------------
   localparam int NUM_PORTS = 7;
   localparam int PORT_WIDTH = 8;
   localparam logic [7:0] DIR_READ_VALUE = 8'hff;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] TIMER_F_RESET = 8'h00;
   // Bits of timer F control that are write-only; these read as one.
   localparam logic [7:0] TIMER_F_WO_MASK = 8'hf0;
   localparam logic [31:0] PSLVERR_NONE = 32'h0;

   //-----------------------------------------------------------------
   // Register indices, as printed
   //-----------------------------------------------------------------
   localparam logic [15:0] IDX_TIMER_F_CONTROL = 16'hffb6;
   localparam logic [15:0] IDX_PORT1_DATA = 16'hffd4;
   localparam logic [15:0] IDX_PORT2_DATA = 16'hffd5;
   localparam logic [15:0] IDX_PORT5_DATA = 16'hffd8;
   localparam logic [15:0] IDX_PORT6_DATA = 16'hffd9;
   localparam logic [15:0] IDX_PORT7_DATA = 16'hffda;
   localparam logic [15:0] IDX_PORT8_DATA = 16'hffdb;
   localparam logic [15:0] IDX_PORTA_DATA = 16'hffdd;
   localparam logic [15:0] IDX_PORT1_DIRECTION = 16'hffe4;
   localparam logic [15:0] IDX_PORT2_DIRECTION = 16'hffe5;
   localparam logic [15:0] IDX_PORT5_DIRECTION = 16'hffe8;
   localparam logic [15:0] IDX_PORT6_DIRECTION = 16'hffe9;
   localparam logic [15:0] IDX_PORT7_DIRECTION = 16'hffea;
   localparam logic [15:0] IDX_PORT8_DIRECTION = 16'hffeb;
   localparam logic [15:0] IDX_PORTA_DIRECTION = 16'hffed;
   localparam int ADDR_WIDTH = 18;

   // Data and direction indices, in port order 1, 2, 5, 6, 7, 8, A.
   localparam logic [NUM_PORTS*16-1:0] DATA_IDX_TABLE = {IDX_PORTA_DATA, IDX_PORT8_DATA, IDX_PORT7_DATA,
      IDX_PORT6_DATA, IDX_PORT5_DATA, IDX_PORT2_DATA, IDX_PORT1_DATA};
   localparam logic [NUM_PORTS*16-1:0] DIR_IDX_TABLE = {IDX_PORTA_DIRECTION, IDX_PORT8_DIRECTION,
      IDX_PORT7_DIRECTION, IDX_PORT6_DIRECTION, IDX_PORT5_DIRECTION, IDX_PORT2_DIRECTION, IDX_PORT1_DIRECTION};

   //-----------------------------------------------------------------
   // Carrier types
   //-----------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_WIDTH-1:0] paddr;
      logic [31:0] pwdata;
   } pdr_apb_req_t;

   typedef struct packed {
      logic [7:0] out_val;
      logic [7:0] out_en;
   } pdr_pin_drive_t;
endpackage

// >>> pdr_port.sv
// Purpose: One eight-bit port: direction and data storage plus read value.
// Assumes: Pin inputs are synchronous to ref_clk.
// Notes: Outputs drive pins straight from flip-flops.
`timescale 1ns/1ps
module pdr_port (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic dir_wr,
   input wire logic data_wr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] pin_in,
   output logic [7:0] data_rd,
   output pdr_pkg::pdr_pin_drive_t drive
);
   logic [7:0] dir_ff;
   logic [7:0] data_ff;

   //-----------------------------------------------------------------
   // Storage
   //-----------------------------------------------------------------
   // Direction is replaced whole on every write; data likewise.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dir_ff <= pdr_pkg::DIR_RESET;
         data_ff <= pdr_pkg::DATA_RESET;
      end else begin
         if (dir_wr) begin
            dir_ff <= wdata;
         end
         if (data_wr) begin
            data_ff <= wdata;
         end
      end
   end

   // A one in the direction bit enables the pin driver.
   assign drive.out_en = dir_ff;
   assign drive.out_val = data_ff;

   // Inputs read the pin, outputs read the stored bit.
   assign data_rd = (dir_ff & data_ff) | (~dir_ff & pin_in);
endmodule // pdr_port

// >>> pdr_top.sv
// Purpose: APB slave holding the port direction and data registers and timer F control.
// Assumes: Single clock ref_clk at 25 MHz, synchronous active-high srst.
// Notes: Zero-wait-state slave; unmapped addresses read zero with no error.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module pdr_top (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [55:0] pin_in,
   output logic [55:0] pin_out,
   output logic [55:0] pin_oe,
   output logic [7:0] timer_f_control
);
   //-----------------------------------------------------------------
   // Decode
   //-----------------------------------------------------------------
   logic [15:0] idx;
   logic setup;
   logic wr_low;
   logic [pdr_pkg::NUM_PORTS-1:0] data_hit;
   logic [pdr_pkg::NUM_PORTS-1:0] dir_hit;
   logic [pdr_pkg::NUM_PORTS*8-1:0] data_rd;
   logic [pdr_pkg::NUM_PORTS*8-1:0] drv_val;
   logic [pdr_pkg::NUM_PORTS*8-1:0] drv_en;
   logic tf_hit;
   logic [7:0] tf_ff;
   logic [7:0] nxt_rdata;
   logic [31:0] prdata_ff;
   logic [7:0] tf_rd;

   // The register index is the byte address divided by four.
   assign idx = paddr[17:2];
   assign setup = psel & ~penable;
   // A write takes effect in the access cycle only if the low lane is enabled.
   assign wr_low = psel & penable & pwrite & pstrb[0];
   assign tf_hit = (idx == pdr_pkg::IDX_TIMER_F_CONTROL);

   //-----------------------------------------------------------------
   // Ports
   //-----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < pdr_pkg::NUM_PORTS; g++) begin : g_port
         pdr_pkg::pdr_pin_drive_t drv;
         // The data index also selects the input pins on read.
         assign data_hit[g] = (idx == pdr_pkg::DATA_IDX_TABLE[g*16 +: 16]);
         assign dir_hit[g] = (idx == pdr_pkg::DIR_IDX_TABLE[g*16 +: 16]);
         pdr_port u_port (
            .ref_clk(ref_clk),
            .srst(srst),
            .dir_wr(wr_low & dir_hit[g]),
            .data_wr(wr_low & data_hit[g]),
            .wdata(pwdata[7:0]),
            .pin_in(pin_in[g*8 +: 8]),
            .data_rd(data_rd[g*8 +: 8]),
            .drive(drv)
         );
         assign drv_val[g*8 +: 8] = drv.out_val;
         assign drv_en[g*8 +: 8] = drv.out_en;
      end
   endgenerate

   //-----------------------------------------------------------------
   // Read mux
   //-----------------------------------------------------------------
   // Write-only timer bits read as one, whatever was stored.
   assign tf_rd = tf_ff | pdr_pkg::TIMER_F_WO_MASK;

   // Direction registers always read all ones.
   always_comb begin
      nxt_rdata = 8'h00;
      for (int i = 0; i < pdr_pkg::NUM_PORTS; i++) begin
         if (data_hit[i]) begin
            nxt_rdata = data_rd[i*8 +: 8];
         end
         if (dir_hit[i]) begin
            nxt_rdata = pdr_pkg::DIR_READ_VALUE;
         end
      end
      if (tf_hit) begin
         nxt_rdata = tf_rd;
      end
   end

   // Read data is captured in the setup cycle, ready in the access cycle.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prdata_ff <= 32'h0000_0000;
         tf_ff <= pdr_pkg::TIMER_F_RESET;
      end else begin
         if (setup & ~pwrite) begin
            prdata_ff <= {24'h00_0000, nxt_rdata};
         end
         if (wr_low & tf_hit) begin
            tf_ff <= pwdata[7:0];
         end
      end
   end

   // Pin drives registered inside each port are registered once more here.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pin_out <= 56'h0;
         pin_oe <= 56'h0;
      end else begin
         pin_out <= drv_val;
         pin_oe <= drv_en;
      end
   end

   assign prdata = prdata_ff;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign timer_f_control = tf_ff;
endmodule // pdr_top

// >>> tb_pdr_top.sv
// Purpose: Self-checking bench for the port register block.
// Assumes: Zero-wait APB slave; pins are sampled in the setup cycle.
// Notes: The driver queues expected read data; a monitor compares it.
`timescale 1ns/1ps
module tb_pdr_top;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [55:0] pin_in = 56'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [55:0] pin_out;
   logic [55:0] pin_oe;
   logic [7:0] timer_f_control;
   logic [7:0] dir [7] = '{default: 8'h0};
   logic [7:0] dat [7] = '{default: 8'h0};
   logic [7:0] tf = 8'h0;
   logic [31:0] exp_q [$];
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   pdr_top i_dut (.*);
   // Clock at 25 MHz and a cycle ceiling against hangs.
   initial forever #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   // One APB transfer; the model is updated and read data queued.
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      logic [7:0] e;
      logic [55:0] pv;
      @(posedge ref_clk);
      e = 8'h0;
      pv = 56'({$urandom(), $urandom()});
      for (int p = 0; p < 7; p++) begin
         if (idx == pdr_pkg::DIR_IDX_TABLE[p*16 +: 16]) begin
            if (w && pstrb[0]) dir[p] = d;
            e = 8'hff;
         end
         if (idx == pdr_pkg::DATA_IDX_TABLE[p*16 +: 16]) begin
            if (w && pstrb[0]) dat[p] = d;
            e = dir[p] & dat[p] | ~dir[p] & pv[p*8 +: 8];
         end
      end
      if (idx == 16'hffb6) begin
         if (w && pstrb[0]) tf = d;
         e = {4'hf, tf[3:0]};
      end
      if (!w) exp_q.push_back({24'h0, e});
      pin_in <= pv;
      paddr <= {14'h0, idx, 2'b00};
      pwrite <= w;
      pwdata <= {24'h0, d};
      psel <= 1'b1;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic check_pins();
      repeat (3) @(posedge ref_clk);
      for (int p = 0; p < 7; p++) begin
         chk("pin_oe", 32'(dir[p]), 32'(pin_oe[p*8 +: 8]));
         chk("pin_out", 32'(dat[p]), 32'(pin_out[p*8 +: 8]));
      end
      chk("timer_f_control", 32'(tf), 32'(timer_f_control));
   endtask
   // Monitor: each read answer is compared with the oldest note.
   always @(posedge ref_clk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         chk("prdata", exp_q.pop_front(), prdata);
         chk("pslverr", 32'h0, 32'(pslverr));
      end
   end
   // Main sequence: every port, read-modify-write hazard, timer, refusals.
   initial begin
      void'($urandom(32'hbb0dfad2));
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      check_pins();
      for (int p = 0; p < 7; p++) begin
         apb(1'b0, pdr_pkg::DIR_IDX_TABLE[p*16 +: 16], 8'h0);
         apb(1'b1, pdr_pkg::DIR_IDX_TABLE[p*16 +: 16], 8'($urandom()));
         apb(1'b1, pdr_pkg::DATA_IDX_TABLE[p*16 +: 16], 8'($urandom()));
         apb(1'b0, pdr_pkg::DATA_IDX_TABLE[p*16 +: 16], 8'h0);
      end
      check_pins();
      apb(1'b1, 16'hffe9, 8'h3f);
      apb(1'b0, 16'hffe9, 8'h0);
      apb(1'b1, 16'hffe9, 8'hff & 8'hfe);
      check_pins();
      apb(1'b1, 16'hffe9, 8'h3f & 8'hfe);
      check_pins();
      apb(1'b1, 16'hffb6, 8'($urandom()));
      apb(1'b0, 16'hffb6, 8'h0);
      pstrb <= 4'he;
      apb(1'b1, 16'hffe9, 8'h5a);
      pstrb <= 4'hf;
      apb(1'b1, 16'hffe6, 8'h77);
      apb(1'b0, 16'hffe6, 8'h0);
      check_pins();
      // A reset in mid-run must return every pin to input and clear all storage.
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      dir = '{default: 8'h0};
      dat = '{default: 8'h0};
      tf = 8'h0;
      check_pins();
      apb(1'b0, 16'hffd9, 8'h0);
      print_verdict();
   end
endmodule // tb_pdr_top
